// ==== rtl/smcg_params.svh ====
`ifndef SMCG_PARAMS_SVH
`define SMCG_PARAMS_SVH
// Sleep mode select encodings
`define SMCG_SM_IDLE 3'h0
`define SMCG_SM_ADCQ 3'h1
`define SMCG_SM_PDOWN 3'h2
`define SMCG_SM_PSAVE 3'h3
`define SMCG_SM_STBY 3'h6
`define SMCG_SM_XSTBY 3'h7
// Extra halt after wake by interrupt, in cycles
`define SMCG_IRQ_HALT_CYC 4'h4
// Standby wake time, in cycles
`define SMCG_STBY_WAKE_CYC 16'h0006
// Start-up count width
`define SMCG_CNT_W 16
// Number of gated peripherals, SRAM blocks
`define SMCG_NPERIPH 16
`define SMCG_NSRAM 4
// Timer 2 mask bit positions
`define SMCG_T2_OVF_BIT 0
`define SMCG_T2_CMPA_BIT 1
`define SMCG_T2_CMPB_BIT 2
`endif

// ==== rtl/smcg_pkg.sv ====
package smcg_pkg;
  typedef enum logic [2:0] {
    SMCG_ACTIVE = 3'b000,
    SMCG_SLEEP = 3'b001,
    SMCG_STARTUP = 3'b010,
    SMCG_HALT = 3'b011
  } smcg_state_e;
endpackage : smcg_pkg

// ==== rtl/smcg_sleep_ctrl.sv ====
`timescale 1ns/1ps
`include "smcg_params.svh"
module smcg_sleep_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Core side
  input wire logic sleep_instr,
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic global_irq_enable,
  input wire logic [`SMCG_CNT_W-1:0] clock_source_fuses,
  input wire logic trx_crystal_sel,
  input wire logic main_crystal_sel,
  // Timer 2 setup
  input wire logic [7:0] timer2_interrupt_mask,
  input wire logic timer2_enabled,
  input wire logic timer2_async,
  // Wake sources
  input wire logic ext_reset_req,
  input wire logic wdt_reset_req,
  input wire logic bod_reset_req,
  input wire logic twi_addr_match,
  input wire logic [3:0] upper_external_irqs,
  input wire logic [3:0] lower_external_irqs,
  input wire logic pin_change_irq,
  input wire logic symcnt_irq,
  input wire logic t2_ovf_evt,
  input wire logic t2_cmpa_evt,
  input wire logic t2_cmpb_evt,
  input wire logic other_irq,
  input wire logic adc_done_irq,
  // Analog users and power
  input wire logic adc_enabled,
  input wire logic acomp_enabled,
  input wire logic acomp_uses_ref,
  input wire logic brownout_level_fuses,
  input wire logic trx_asleep,
  input wire logic [`SMCG_NPERIPH-1:0] power_reduction_reg,
  input wire logic [`SMCG_NSRAM-1:0] sram_reduction,
  input wire logic radio_reduction,
  // Clock enables and controls
  output logic clk_cpu_en,
  output logic clk_flash_en,
  output logic clk_io_en,
  output logic clk_adc_en,
  output logic clk_asy_en,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic t2_sync_clk_en,
  output logic [`SMCG_NPERIPH-1:0] periph_clk_en,
  output logic [`SMCG_NPERIPH-1:0] periph_reg_access,
  output logic [`SMCG_NSRAM-1:0] sram_retention_switch,
  output logic radio_reset,
  output logic adc_power,
  output logic acomp_power,
  output logic bod_power,
  output logic vref_power,
  output logic cpu_run,
  output logic reset_wake,
  output logic deep_sleep
);

  smcg_pkg::smcg_state_e state_r;
  smcg_pkg::smcg_state_e state_nxt;
  logic [2:0] mode_r;
  logic [`SMCG_CNT_W-1:0] cnt_r;
  logic [`SMCG_CNT_W-1:0] cnt_nxt;
  logic irq_wake_r;
  logic sleeping;
  logic valid_mode;
  logic upper_level;
  logic t2_wake;
  logic rst_wake;
  logic wake;
  logic m_idle;
  logic m_adcq;
  logic m_pd_like;
  logic m_ps_like;
  logic m_osc_on;
  logic enter;

  // Reserved or crystal-less standby selects are refused, core stays running
  always_comb begin
    case (sleep_mode_select)
      `SMCG_SM_IDLE, `SMCG_SM_ADCQ, `SMCG_SM_PDOWN, `SMCG_SM_PSAVE: valid_mode = 1'b1;
      `SMCG_SM_STBY, `SMCG_SM_XSTBY: valid_mode = trx_crystal_sel;
      default: valid_mode = 1'b0;
    endcase
  end

  // Sleep needs both the enable bit and the instruction
  assign enter = sleep_instr && sleep_enable_bit && valid_mode;

  // Decoded latched mode
  assign sleeping = (state_r == smcg_pkg::SMCG_SLEEP);
  assign m_idle = (mode_r == `SMCG_SM_IDLE);
  assign m_adcq = (mode_r == `SMCG_SM_ADCQ);
  assign m_ps_like = (mode_r == `SMCG_SM_PSAVE) || (mode_r == `SMCG_SM_XSTBY);
  assign m_pd_like = (mode_r == `SMCG_SM_PDOWN) || (mode_r == `SMCG_SM_STBY);
  assign m_osc_on = (mode_r == `SMCG_SM_STBY) || (mode_r == `SMCG_SM_XSTBY);

  // Wake sources; a level on the upper lines must be held until seen
  assign upper_level = |upper_external_irqs;
  assign rst_wake = ext_reset_req || wdt_reset_req || bod_reset_req;
  assign t2_wake = global_irq_enable && timer2_enabled &&
    ((t2_ovf_evt && timer2_interrupt_mask[`SMCG_T2_OVF_BIT]) ||
     (t2_cmpa_evt && timer2_interrupt_mask[`SMCG_T2_CMPA_BIT]) ||
     (t2_cmpb_evt && timer2_interrupt_mask[`SMCG_T2_CMPB_BIT]));

  // Wake set per mode
  always_comb begin
    wake = rst_wake || twi_addr_match || upper_level || pin_change_irq;
    if (m_idle) begin
      wake = wake || (|lower_external_irqs) || symcnt_irq || t2_wake || other_irq || adc_done_irq;
    end else if (m_adcq) begin
      wake = wake || (|lower_external_irqs) || symcnt_irq || t2_wake || adc_done_irq;
    end else if (m_ps_like) begin
      wake = wake || (|lower_external_irqs) || symcnt_irq || t2_wake;
    end else begin
      wake = wake || (|lower_external_irqs) || symcnt_irq;
    end
  end

  // Sequencer: sleep, start-up delay, interrupt halt, run
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      smcg_pkg::SMCG_ACTIVE: begin
        if (enter) begin
          state_nxt = smcg_pkg::SMCG_SLEEP;
        end
      end
      smcg_pkg::SMCG_SLEEP: begin
        if (wake) begin
          state_nxt = smcg_pkg::SMCG_STARTUP;
          if (m_osc_on) begin
            cnt_nxt = `SMCG_STBY_WAKE_CYC;
          end else if (m_pd_like || m_ps_like) begin
            cnt_nxt = clock_source_fuses;
          end else begin
            cnt_nxt = `SMCG_CNT_W'(1);
          end
        end
      end
      smcg_pkg::SMCG_STARTUP: begin
        if (cnt_r <= `SMCG_CNT_W'(1)) begin
          if (irq_wake_r) begin
            state_nxt = smcg_pkg::SMCG_HALT;
            cnt_nxt = `SMCG_CNT_W'(`SMCG_IRQ_HALT_CYC);
          end else begin
            state_nxt = smcg_pkg::SMCG_ACTIVE;
          end
        end else begin
          cnt_nxt = cnt_r - `SMCG_CNT_W'(1);
        end
      end
      smcg_pkg::SMCG_HALT: begin
        if (cnt_r <= `SMCG_CNT_W'(1)) begin
          state_nxt = smcg_pkg::SMCG_ACTIVE;
        end else begin
          cnt_nxt = cnt_r - `SMCG_CNT_W'(1);
        end
      end
      default: state_nxt = smcg_pkg::SMCG_ACTIVE;
    endcase
  end

  // State and counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= smcg_pkg::SMCG_ACTIVE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Mode latched at entry so a later write cannot change gating mid-sleep
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= `SMCG_SM_IDLE;
    end else if (state_r == smcg_pkg::SMCG_ACTIVE && enter) begin
      mode_r <= sleep_mode_select;
    end
  end

  // Reset wakes restart from the vector, so no interrupt halt
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_wake_r <= 1'b0;
      reset_wake <= 1'b0;
    end else if (sleeping && wake) begin
      irq_wake_r <= !rst_wake;
      reset_wake <= rst_wake;
    end else if (state_nxt == smcg_pkg::SMCG_ACTIVE) begin
      reset_wake <= 1'b0;
    end
  end

  // Domain clock enables, from next state so they switch on the same edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_run <= 1'b1;
      clk_cpu_en <= 1'b1;
      clk_flash_en <= 1'b1;
      clk_io_en <= 1'b1;
      clk_adc_en <= 1'b1;
      clk_asy_en <= 1'b1;
      main_osc_en <= 1'b1;
      timer_osc_en <= 1'b1;
      t2_sync_clk_en <= 1'b1;
    end else begin
      cpu_run <= (state_nxt == smcg_pkg::SMCG_ACTIVE);
      clk_cpu_en <= (state_nxt == smcg_pkg::SMCG_ACTIVE);
      clk_flash_en <= (state_nxt == smcg_pkg::SMCG_ACTIVE);
      if (state_nxt == smcg_pkg::SMCG_SLEEP) begin
        clk_io_en <= sel_is(state_r, sleep_mode_select, mode_r, 2'h0);
        clk_adc_en <= sel_is(state_r, sleep_mode_select, mode_r, 2'h1);
        clk_asy_en <= sel_is(state_r, sleep_mode_select, mode_r, 2'h1) ||
          (ps_sel(state_r, sleep_mode_select, mode_r) && timer2_enabled && timer2_async);
        main_osc_en <= sel_is(state_r, sleep_mode_select, mode_r, 2'h1) ||
          osc_sel(state_r, sleep_mode_select, mode_r) || !main_crystal_sel ||
          (ps_sel(state_r, sleep_mode_select, mode_r) && timer2_enabled && !timer2_async);
        timer_osc_en <= sel_is(state_r, sleep_mode_select, mode_r, 2'h1) ||
          (ps_sel(state_r, sleep_mode_select, mode_r) && timer2_enabled && timer2_async);
        t2_sync_clk_en <= ps_sel(state_r, sleep_mode_select, mode_r) &&
          timer2_enabled && !timer2_async;
      end else begin
        clk_io_en <= 1'b1;
        clk_adc_en <= 1'b1;
        clk_asy_en <= 1'b1;
        main_osc_en <= 1'b1;
        timer_osc_en <= 1'b1;
        t2_sync_clk_en <= 1'b1;
      end
    end
  end

  // Mode seen by the gating logic: the entering select, or the latched one
  function automatic logic [2:0] eff_mode(input smcg_pkg::smcg_state_e st,
                                          input logic [2:0] sel, input logic [2:0] lat);
    eff_mode = (st == smcg_pkg::SMCG_ACTIVE) ? sel : lat;
  endfunction : eff_mode

  // True in idle (code 0) or, with lvl 1, in idle or ADC quiet
  function automatic logic sel_is(input smcg_pkg::smcg_state_e st, input logic [2:0] sel,
                                  input logic [2:0] lat, input logic [1:0] lvl);
    logic [2:0] m;
    m = eff_mode(st, sel, lat);
    sel_is = (m == `SMCG_SM_IDLE) || (lvl == 2'h1 && m == `SMCG_SM_ADCQ);
  endfunction : sel_is

  function automatic logic ps_sel(input smcg_pkg::smcg_state_e st, input logic [2:0] sel,
                                  input logic [2:0] lat);
    logic [2:0] m;
    m = eff_mode(st, sel, lat);
    ps_sel = (m == `SMCG_SM_PSAVE) || (m == `SMCG_SM_XSTBY);
  endfunction : ps_sel

  function automatic logic osc_sel(input smcg_pkg::smcg_state_e st, input logic [2:0] sel,
                                   input logic [2:0] lat);
    logic [2:0] m;
    m = eff_mode(st, sel, lat);
    osc_sel = (m == `SMCG_SM_STBY) || (m == `SMCG_SM_XSTBY);
  endfunction : osc_sel

  // Per-peripheral gating; the peripheral keeps its flops, so state survives
  genvar gi;
  generate
    for (gi = 0; gi < `SMCG_NPERIPH; gi = gi + 1) begin : g_periph
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          periph_clk_en[gi] <= 1'b1;
          periph_reg_access[gi] <= 1'b1;
        end else begin
          periph_clk_en[gi] <= !power_reduction_reg[gi];
          periph_reg_access[gi] <= !power_reduction_reg[gi];
        end
      end
    end
  endgenerate

  // SRAM switch and radio reset do not retain state, unlike other peripherals
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sram_retention_switch <= '1;
      radio_reset <= 1'b0;
    end else begin
      sram_retention_switch <= ~sram_reduction;
      radio_reset <= radio_reduction;
    end
  end

  // Analog power; deep sleep is power-down/save or either standby with the radio idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_power <= 1'b0;
      acomp_power <= 1'b0;
      bod_power <= 1'b0;
      vref_power <= 1'b0;
      deep_sleep <= 1'b0;
    end else begin
      deep_sleep <= sleeping && (m_pd_like || m_ps_like) && (trx_asleep || radio_reduction);
      adc_power <= adc_enabled;
      acomp_power <= acomp_enabled && (!sleeping || m_idle || m_adcq || acomp_uses_ref);
      bod_power <= brownout_level_fuses && !deep_sleep;
      vref_power <= (brownout_level_fuses && !deep_sleep) || adc_enabled ||
        (acomp_enabled && (!sleeping || m_idle || m_adcq || acomp_uses_ref));
    end
  end
endmodule : smcg_sleep_ctrl

// ==== sim/smcg_sleep_ctrl_properties.sv ====
`timescale 1ns/1ps
`include "smcg_params.svh"
module smcg_sleep_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Causes
  input wire logic sleep_instr,
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic adc_enabled,
  input wire logic acomp_enabled,
  input wire logic brownout_level_fuses,
  input wire logic [`SMCG_NPERIPH-1:0] power_reduction_reg,
  input wire logic [`SMCG_NSRAM-1:0] sram_reduction,
  input wire logic radio_reduction,
  input wire logic acomp_uses_ref,
  input wire logic trx_asleep,
  // Effects
  input wire logic clk_cpu_en,
  input wire logic clk_adc_en,
  input wire logic [`SMCG_NPERIPH-1:0] periph_clk_en,
  input wire logic [`SMCG_NPERIPH-1:0] periph_reg_access,
  input wire logic [`SMCG_NSRAM-1:0] sram_retention_switch,
  input wire logic radio_reset,
  input wire logic adc_power,
  input wire logic acomp_power,
  input wire logic bod_power,
  input wire logic vref_power,
  input wire logic cpu_run,
  input wire logic deep_sleep
);
  logic armed_r;
  logic users;
  // Outputs lag their inputs one edge, so the first edge after reset is skipped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'h0;
    end else begin
      armed_r <= 1'h1;
    end
  end
  // Any party that needs the reference
  assign users = adc_enabled | acomp_enabled | brownout_level_fuses;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sleep_entry_a: assert property (cpu_run && sleep_instr && sleep_enable_bit
    && sleep_mode_select == 3'h2 |-> ##[1:2] (!cpu_run && !clk_cpu_en))
    else $error("power-down request left the core running");
  refused_req_a: assert property (armed_r && cpu_run && !$past(sleep_instr) && sleep_instr
    && (!sleep_enable_bit || sleep_mode_select inside {3'h4, 3'h5}) |=> cpu_run[*2])
    else $error("refused request halted the core");
  periph_gate_a: assert property (armed_r |-> periph_clk_en == ~$past(power_reduction_reg))
    else $error("peripheral clock does not follow reduction bits");
  reg_access_a: assert property (armed_r |-> periph_reg_access == ~$past(power_reduction_reg))
    else $error("register access open on a stopped peripheral");
  sram_switch_a: assert property (armed_r |-> sram_retention_switch == ~$past(sram_reduction))
    else $error("memory switch does not follow its reduction bit");
  radio_held_a: assert property (armed_r |-> radio_reset == $past(radio_reduction))
    else $error("radio reset does not follow its reduction bit");
  bod_off_a: assert property (armed_r && $past(deep_sleep) |-> !bod_power)
    else $error("brown-out detector powered in deep sleep");
  vref_users_a: assert property (armed_r && vref_power |-> $past(users) || $past(users, 2))
    else $error("reference powered with no user");
  adc_kept_a: assert property (armed_r && $past(adc_enabled) && !deep_sleep
    && !$past(deep_sleep) |-> adc_power)
    else $error("enabled converter lost power");
  // A stopped converter clock means the core sleeps in a deep mode
  acomp_off_a: assert property (armed_r && !clk_adc_en && !acomp_uses_ref |=> !acomp_power)
    else $error("comparator powered in a deep sleep mode");
  deep_entry_a: assert property (armed_r && !clk_adc_en && (trx_asleep || radio_reduction)
    |=> deep_sleep)
    else $error("deep sleep not flagged with the radio idle");
endmodule : smcg_sleep_ctrl_chk

bind smcg_sleep_ctrl smcg_sleep_ctrl_chk chk (.*);

// ==== sim/smcg_wake_partner.sv ====
`timescale 1ns/1ps
module smcg_wake_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Trigger and observation
  input wire logic fire,
  input wire logic cpu_run,
  // Wake level
  output logic wake_lvl
);
  // A short pulse could be missed while clocks restart, so hold until the core runs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wake_lvl <= 1'h0;
    end else if (fire) begin
      wake_lvl <= 1'h1;
    end else if (cpu_run) begin
      wake_lvl <= 1'h0;
    end
  end
endmodule : smcg_wake_partner

// ==== sim/smcg_sleep_ctrl_tb.sv ====
`timescale 1ns/1ps
`include "smcg_params.svh"
module smcg_sleep_ctrl_tb;
  logic clk = 0, rst_b = 0, sleep_instr = 0, sleep_enable_bit = 1, global_irq_enable = 1;
  logic trx_crystal_sel = 1, main_crystal_sel = 1, timer2_enabled = 1, timer2_async = 1;
  logic adc_enabled = 0, acomp_enabled = 0, acomp_uses_ref = 0, brownout_level_fuses = 0;
  logic trx_asleep = 0, radio_reduction = 0, other_irq = 0, adc_done_irq = 0, t2_cmpa_evt = 0;
  logic fire = 0, live = 0, t2a;
  logic [2:0] sleep_mode_select = 3'h0;
  logic [3:0] wk = 4'h0, sram_reduction = 4'h0;
  logic [4:0] exp, mask;
  logic [7:0] timer2_interrupt_mask = 8'h01;
  logic [15:0] clock_source_fuses = 16'h0003, power_reduction_reg = 16'h0000;
  wire ext_reset_req = 1'h0, bod_reset_req = 1'h0, twi_addr_match = 1'h0, symcnt_irq = 1'h0;
  wire t2_cmpb_evt = 1'h0, pin_change_irq;
  wire wdt_reset_req = wk[0], t2_ovf_evt = wk[1];
  wire [3:0] upper_external_irqs = {3'h0, wk[2]}, lower_external_irqs = {3'h0, wk[3]};
  logic clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, clk_asy_en, main_osc_en, timer_osc_en;
  logic t2_sync_clk_en, radio_reset, adc_power, acomp_power, bod_power, vref_power, cpu_run;
  logic reset_wake, deep_sleep;
  logic [15:0] periph_clk_en, periph_reg_access;
  logic [3:0] sram_retention_switch;
  int errors = 0, comparisons = 0, seed = 43170, n, lat, i, m;
  int modes[6] = '{0, 1, 2, 3, 6, 7};

  smcg_sleep_ctrl dut (.*);
  smcg_wake_partner partner (.clk(clk), .rst_b(rst_b), .fire(fire), .cpu_run(cpu_run),
    .wake_lvl(pin_change_irq));

  always #5 clk = ~clk;

  task automatic check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // One-cycle sleep pulse, then let the gating settle
  task automatic go_sleep(input logic [2:0] sel);
    @(negedge clk);
    sleep_mode_select = sel;
    sleep_instr = 1'h1;
    @(negedge clk);
    sleep_instr = 1'h0;
    repeat (3) @(negedge clk);
  endtask : go_sleep

  // Bounded wait for the core to run again; c counts cycles
  task automatic wait_run(output int c);
    c = 0;
    while (cpu_run !== 1'h1 && c < 300) begin
      @(negedge clk);
      c++;
    end
    if (c == 300) begin
      errors++;
      print_verdict();
    end
  endtask : wait_run

  // Start-up count of the mode; a zero fuse count still costs one cycle
  function automatic int start_n(int md);
    if (md >= 6) return 6;
    if (md >= 2) return (clock_source_fuses == 16'h0000) ? 1 : int'(clock_source_fuses);
    return 1;
  endfunction : start_n

  // Gating inputs change every cycle; the previous value must show at the outputs
  always @(negedge clk) begin
    if (live) begin
      check(periph_clk_en === ~power_reduction_reg && periph_reg_access === periph_clk_en,
        "peripheral gating");
      check(sram_retention_switch === ~sram_reduction && radio_reset === radio_reduction,
        "memory and radio");
    end
    // No modelled peripheral holds resources, so gating at any time is safe here
    power_reduction_reg = 16'($random(seed));
    {sram_reduction, radio_reduction, adc_enabled, acomp_enabled} = 7'($random(seed));
    {acomp_uses_ref, brownout_level_fuses, trx_asleep} = 3'($random(seed));
  end

  initial begin
    repeat (3) @(negedge clk);
    rst_b = 1'h1;
    live <= 1'h1;
    // Every mode twice, with the enable model from the clock domain table
    for (i = 0; i < 12; i++) begin
      m = modes[i % 6];
      clock_source_fuses = 16'(2 + {$random(seed)} % 16);
      {main_crystal_sel, timer2_async, timer2_enabled} = 3'($random(seed));
      go_sleep(3'(m));
      t2a = timer2_enabled & timer2_async;
      case (m)
        0: exp = 5'h0F;
        1: exp = 5'h07;
        2: exp = 5'h00;
        3: exp = {3'h0, t2a, timer2_enabled & ~timer2_async};
        6: exp = 5'h01;
        default: exp = {3'h0, t2a, 1'h1};
      endcase
      mask = main_crystal_sel ? 5'h1F : 5'h1E;
      check(({clk_cpu_en, clk_io_en, clk_adc_en, clk_asy_en, main_osc_en} & mask) === (exp & mask),
        "mode clocks");
      check(clk_flash_en === 1'h0 && timer_osc_en === (m < 2 || (m % 4 == 3 && t2a)) &&
        t2_sync_clk_en === (m % 4 == 3 && timer2_enabled && !timer2_async), "timer clocks");
      fire = 1'h1;
      @(negedge clk);
      fire = 0;
      wait_run(lat);
      n = start_n(m) + 4;
      check(lat >= n && lat <= n + 6, "wake time");
    end
    // Reserved codes, standby without the crystal, enable low: nothing happens
    for (i = 0; i < 4; i++) begin
      trx_crystal_sel = (i != 2);
      sleep_enable_bit = (i != 3);
      go_sleep(i < 2 ? 3'(4 + i) : 3'h6);
      check(cpu_run === 1'h1 && clk_cpu_en === 1'h1, "refused");
    end
    sleep_enable_bit = 1'h1;
    // Power-down ignores sources outside its list, then wakes on a lower line
    go_sleep(3'h2);
    repeat (20) begin
      @(negedge clk);
      {other_irq, adc_done_irq, t2_cmpa_evt} = 3'($random(seed));
    end
    check(cpu_run === 1'h0, "stray wake");
    {other_irq, adc_done_irq, t2_cmpa_evt} = 3'h0;
    wk = 4'h8;
    wait_run(lat);
    wk = 4'h0;
    check(lat >= start_n(2) + 4 && lat <= start_n(2) + 9, "lower wake");
    // Power-save: overflow wakes only with its mask bit and the global enable
    {timer2_enabled, timer2_async, global_irq_enable, timer2_interrupt_mask} = {3'h6, 8'h01};
    go_sleep(3'h3);
    wk = 4'h2;
    repeat (10) @(negedge clk);
    timer2_interrupt_mask = 8'h00;
    global_irq_enable = 1'h1;
    repeat (10) @(negedge clk);
    check(cpu_run === 1'h0, "masked timer wake");
    timer2_interrupt_mask = 8'h01;
    wait_run(lat);
    wk = 4'h0;
    check(lat <= start_n(3) + 9, "timer wake");
    // Reset wake skips the four halt cycles
    go_sleep(3'h2);
    wk = 4'h1;
    repeat (2) @(negedge clk);
    check(reset_wake === 1'h1, "reset wake flag");
    wait_run(lat);
    wk = 4'h0;
    check(lat + 2 >= start_n(2) && lat + 2 <= start_n(2) + 4, "reset wake");
    // Converter-quiet mode wakes on an upper level line
    go_sleep(3'h1);
    wk = 4'h4;
    wait_run(lat);
    wk = 4'h0;
    check(lat >= 5 && lat <= 10, "upper level wake");
    print_verdict();
  end
endmodule : smcg_sleep_ctrl_tb
